// ---- core/snp_spi_nvram.sv ----
// SPI slave command logic with write latch, block protect and array.
// Assumes pins arrive asynchronously; nonvolatile engine is on clk.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1: Status, array and special writes accepted only while latch is set.
// RQ2: Latch is cleared at power-up reset.
// RQ3: Write commands with latch clear are ignored until the next frame.
// RQ4: Set-latch opcode sets the latch.
// RQ5: Completed write-type command clears the latch at frame end.
// RQ6: Clear-latch opcode clears the latch at chip-select rise.
// RQ7: Protect level selects none, top quarter, top half or whole array.
// RQ8: Protect bits written by status write, read by status read.
// RQ9: Guard pin low with guard enable set rejects status writes.
// RQ10: Guard enable clear makes the guard pin ignored.
// RQ11: Guard condition sampled at frame start, not mid-write.
// RQ12: Protected segments never written; clear latch blocks all writes.
// RQ13: Array commands refused during save or restore; busy shown.
// RQ14: Read frame is opcode plus three address bytes, A16 in bit 0.
// RQ15: Read data shifted out MSB first on falling clock, input ignored.
// RQ16: Read address increments and wraps from top to zero.
// RQ17: Write frame is opcode, three address bytes, then data bytes.
// RQ18: Each further written byte goes to next address, with wrap.
// RQ19: Host raises chip select after the last byte it wants.
// RQ20: All bytes MSB first; every command starts at chip-select fall.
// RQ21: Status byte: busy 0, latch 1, protect lo 2, hi 3, guard 7.
// RQ22: Set-latch opcode 06h, clear-latch opcode 04h.
// RQ23: Read opcode 03h, write opcode 02h.
// RQ24: 17-bit address counter drops the upper first-byte bits.
// RQ25: Latch set and clear are accepted regardless of any protection.
module snp_spi_nvram #(
	parameter int DEPTH = 131072
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// SPI pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Hardware write guard pin
	input wire logic write_guard_n,
	// Nonvolatile engine
	input wire logic nv_busy,
	output logic store_busy_n,
	output logic save_req,
	output logic restore_req,
	output logic autosave_on_req,
	output logic autosave_off_req,
	// Status view
	output snp_pkg::snp_status_s status
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic cs_s1, cs_s2, cs_d;
	logic sck_s1, sck_s2, sck_d;
	logic si_s1, si_s2;
	logic wg_s1, wg_s2;
	logic cs_fall, cs_rise, sck_rise, sck_fall, byte_done;
	logic [2:0] bit_cnt;
	logic [1:0] addr_cnt;
	logic [7:0] rx, tx, shift_in, rd_byte;
	logic [snp_pkg::ADDR_W-1:0] addr;
	logic [7:0] mem [DEPTH];
	snp_pkg::snp_state_e state;
	logic is_write, guard_block, latch, done_write, clr_pend;
	logic [7:0] spec_op;
	logic spec_pend;
	logic guard_en, prot_hi, prot_lo;
	logic mem_we, stat_we, cmd_done;

	// Block protect decode
	function automatic logic is_prot(input logic [1:0] lvl,
			input logic [snp_pkg::ADDR_W-1:0] a);
		case (lvl)
			snp_pkg::PROT_NONE: is_prot = 1'b0;
			snp_pkg::PROT_QTR: is_prot = (a >= snp_pkg::QTR_BASE);
			snp_pkg::PROT_HALF: is_prot = (a >= snp_pkg::HALF_BASE);
			default: is_prot = 1'b1;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detect
	// ------------------------------------------------------------------
	// Two flops per pin, third stage only for edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{cs_d, cs_s2, cs_s1} <= 3'h7;
			{sck_d, sck_s2, sck_s1} <= 3'h0;
			{si_s2, si_s1} <= 2'h0;
			{wg_s2, wg_s1} <= 2'h3;
		end else begin
			{cs_d, cs_s2, cs_s1} <= {cs_s2, cs_s1, cs_n};
			{sck_d, sck_s2, sck_s1} <= {sck_s2, sck_s1, sck};
			{si_s2, si_s1} <= {si_s1, si};
			{wg_s2, wg_s1} <= {wg_s1, write_guard_n};
		end
	end

	// Frame and clock events; clock edges only count while selected
	assign cs_fall = cs_d & ~cs_s2; // see RQ20
	assign cs_rise = ~cs_d & cs_s2;
	assign sck_rise = ~sck_d & sck_s2 & ~cs_s2;
	assign sck_fall = sck_d & ~sck_s2 & ~cs_s2;
	assign shift_in = {rx[6:0], si_s2}; // see RQ20
	assign byte_done = sck_rise & (bit_cnt == snp_pkg::BIT_LAST);
	assign cmd_done = byte_done & (state == snp_pkg::ST_CMD);

	// ------------------------------------------------------------------
	// Bit and byte shifting
	// ------------------------------------------------------------------
	// Receive shifter and bit counter, restarted at each frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx <= 8'h00;
			bit_cnt <= snp_pkg::BIT_FIRST;
		end else if (cs_s2) begin
			bit_cnt <= snp_pkg::BIT_FIRST;
		end else if (sck_rise) begin
			rx <= shift_in;
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// Frame decoder
	// ------------------------------------------------------------------
	// Opcode decode and frame sequencing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= snp_pkg::ST_CMD;
			is_write <= 1'b0;
		end else if (cs_s2) begin
			state <= snp_pkg::ST_CMD; // see RQ3
		end else if (byte_done) begin
			case (state)
				snp_pkg::ST_CMD: begin
					case (shift_in)
						snp_pkg::OP_READ: begin
							is_write <= 1'b0; // see RQ23
							state <= nv_busy ? snp_pkg::ST_IGNORE :
								snp_pkg::ST_ADDR; // see RQ13
						end
						snp_pkg::OP_WRITE: begin
							is_write <= 1'b1; // see RQ17
							state <= (nv_busy || !latch) ?
								snp_pkg::ST_IGNORE :
								snp_pkg::ST_ADDR; // see RQ1
						end
						snp_pkg::OP_STAT_WR: begin
							state <= latch ? snp_pkg::ST_STWR :
								snp_pkg::ST_IGNORE; // see RQ3
						end
						snp_pkg::OP_STAT_RD: begin
							state <= snp_pkg::ST_STRD; // see RQ8
						end
						default: state <= snp_pkg::ST_IGNORE;
					endcase
				end
				snp_pkg::ST_ADDR: begin
					if (addr_cnt == snp_pkg::ADDR_BYTE_LAST) begin
						state <= is_write ? snp_pkg::ST_WDATA :
							snp_pkg::ST_RDATA; // see RQ14
					end
				end
				snp_pkg::ST_STWR: state <= snp_pkg::ST_IGNORE;
				default: state <= state;
			endcase
		end
	end

	// Address byte count and 17-bit address counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_cnt <= 2'h0;
			addr <= '0;
		end else if (cs_s2) begin
			addr_cnt <= 2'h0;
		end else if (byte_done && state == snp_pkg::ST_ADDR) begin
			addr_cnt <= addr_cnt + 2'h1;
			addr <= {addr[snp_pkg::ADDR_W-snp_pkg::BYTE_W-1:0],
				shift_in}; // see RQ24
		end else if (byte_done && (state == snp_pkg::ST_WDATA ||
				state == snp_pkg::ST_RDATA)) begin
			addr <= addr + 1'b1; // see RQ16 see RQ18
		end
	end

	// ------------------------------------------------------------------
	// Write guard, latch and status bits
	// ------------------------------------------------------------------
	// Guard condition frozen at frame start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			guard_block <= 1'b0;
		end else if (cs_fall) begin
			guard_block <= guard_en & ~wg_s2; // see RQ9 see RQ10 see RQ11
		end
	end

	assign stat_we = byte_done & (state == snp_pkg::ST_STWR) &
		~guard_block; // see RQ9
	assign mem_we = byte_done & (state == snp_pkg::ST_WDATA) &
		~is_prot({prot_hi, prot_lo}, addr); // see RQ7 see RQ12

	// Status register writable bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{guard_en, prot_hi, prot_lo} <= 3'h0;
		end else if (stat_we) begin
			guard_en <= shift_in[snp_pkg::SB_GUARD]; // see RQ8
			prot_hi <= shift_in[snp_pkg::SB_PHI];
			prot_lo <= shift_in[snp_pkg::SB_PLO];
		end
	end

	// Pending frame-end actions
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{done_write, clr_pend, spec_pend} <= 3'h0;
			spec_op <= 8'h00;
		end else if (cs_fall) begin
			{done_write, clr_pend, spec_pend} <= 3'h0;
		end else if (cmd_done) begin
			clr_pend <= (shift_in == snp_pkg::OP_CLR_LATCH);
			spec_op <= shift_in;
			spec_pend <= latch && (shift_in == snp_pkg::OP_SAVE ||
				shift_in == snp_pkg::OP_RESTORE ||
				shift_in == snp_pkg::OP_AUTO_ON ||
				shift_in == snp_pkg::OP_AUTO_OFF); // see RQ1
			done_write <= latch && (shift_in == snp_pkg::OP_STAT_WR ||
				(shift_in == snp_pkg::OP_WRITE && !nv_busy));
		end
	end

	// Write latch: set by opcode, cleared at frame end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch <= 1'b0; // see RQ2
		end else if (cmd_done && shift_in == snp_pkg::OP_SET_LATCH) begin
			latch <= 1'b1; // see RQ4 see RQ25 see RQ22
		end else if (cs_rise && clr_pend) begin
			latch <= 1'b0; // see RQ6 see RQ25
		end else if (cs_rise && (done_write || spec_pend)) begin
			latch <= 1'b0; // see RQ5
		end
	end

	// Special command pulses at frame end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{save_req, restore_req} <= 2'h0;
			{autosave_on_req, autosave_off_req} <= 2'h0;
		end else begin
			save_req <= cs_rise & spec_pend &
				(spec_op == snp_pkg::OP_SAVE); // see RQ1
			restore_req <= cs_rise & spec_pend &
				(spec_op == snp_pkg::OP_RESTORE);
			autosave_on_req <= cs_rise & spec_pend &
				(spec_op == snp_pkg::OP_AUTO_ON);
			autosave_off_req <= cs_rise & spec_pend &
				(spec_op == snp_pkg::OP_AUTO_OFF);
		end
	end

	// Busy pin mirrors the engine, active low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			store_busy_n <= 1'b1;
		end else begin
			store_busy_n <= ~nv_busy; // see RQ13
		end
	end

	// Status byte assembly
	always_comb begin
		status = '0;
		status.pin_guard_enable = guard_en; // see RQ21
		status.protect_level_hi = prot_hi;
		status.protect_level_lo = prot_lo;
		status.write_latch_bit = latch;
		status.busy_flag = nv_busy;
	end

	// ------------------------------------------------------------------
	// Array and serial output
	// ------------------------------------------------------------------
	// Array storage, no reset
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[addr] <= shift_in; // see RQ18
		end
	end

	assign rd_byte = (state == snp_pkg::ST_STRD) ? status : mem[addr];

	// Output shifter, MSB first on falling clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			so <= 1'b0;
			tx <= 8'h00;
		end else if (sck_fall && (state == snp_pkg::ST_RDATA ||
				state == snp_pkg::ST_STRD)) begin
			if (bit_cnt == snp_pkg::BIT_FIRST) begin
				so <= rd_byte[7]; // see RQ15
				tx <= {rd_byte[6:0], 1'b0};
			end else begin
				so <= tx[7];
				tx <= {tx[6:0], 1'b0};
			end
		end
	end

	assign so_oe = ~cs_s2 & (state == snp_pkg::ST_RDATA ||
		state == snp_pkg::ST_STRD);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_latch_set: assert property ( // see RQ4
		cmd_done && shift_in == snp_pkg::OP_SET_LATCH |=> latch)
		else $error("latch not set by set opcode");
	a_latch_clear: assert property ( // see RQ6
		cs_rise && clr_pend |=> !latch)
		else $error("latch not cleared at frame end");
	a_write_clears: assert property ( // see RQ5
		cs_rise && done_write && !clr_pend |=> !latch)
		else $error("latch kept after write command");
	a_mem_latched: assert property ( // see RQ12
		mem_we |-> latch && is_write)
		else $error("array written without latch");
	a_prot_block: assert property ( // see RQ7
		mem_we |-> !(prot_hi && prot_lo) &&
		!(prot_hi && addr >= snp_pkg::HALF_BASE) &&
		!(prot_lo && addr >= snp_pkg::QTR_BASE))
		else $error("protected location written");
	a_guard_block: assert property ( // see RQ9
		stat_we |-> !guard_block && latch)
		else $error("status written while guarded");
	a_busy_pin: assert property ( // see RQ13
		nv_busy |=> !store_busy_n)
		else $error("busy pin not asserted");
	a_read_busy: assert property ( // see RQ13
		cmd_done && shift_in == snp_pkg::OP_READ && nv_busy
		|=> state == snp_pkg::ST_IGNORE)
		else $error("read accepted while busy");
	a_addr_step: assert property ( // see RQ18
		byte_done && state == snp_pkg::ST_WDATA
		|=> addr == $past(addr) + 1'b1)
		else $error("write address did not step");
	a_read_msb: assert property ( // see RQ15
		sck_fall && state == snp_pkg::ST_RDATA &&
		bit_cnt == snp_pkg::BIT_FIRST |=> so == $past(rd_byte[7]))
		else $error("read data not MSB first");

endmodule

`default_nettype wire

// ---- pkg/snp_pkg.sv ----
// Shared constants and types for the serial RAM command logic.
// Assumes one 40 MHz clock domain and an SPI host driving the pins.
`default_nettype none

package snp_pkg;

	// ------------------------------------------------------------------
	// Geometry and timing of the serial frame
	// ------------------------------------------------------------------
	localparam int ADDR_W = 17;
	localparam int BYTE_W = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH = 8'h04;
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_SAVE = 8'h3c;
	localparam logic [7:0] OP_RESTORE = 8'h60;
	localparam logic [7:0] OP_AUTO_ON = 8'h59;
	localparam logic [7:0] OP_AUTO_OFF = 8'h19;

	// ------------------------------------------------------------------
	// Protect levels and segment bases
	// ------------------------------------------------------------------
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam logic [1:0] PROT_QTR = 2'h1;
	localparam logic [1:0] PROT_HALF = 2'h2;
	localparam logic [16:0] QTR_BASE = 17'h18000;
	localparam logic [16:0] HALF_BASE = 17'h10000;

	// Status byte bit positions written by the status write command
	localparam int SB_GUARD = 7;
	localparam int SB_PHI = 3;
	localparam int SB_PLO = 2;

	// Status byte layout, bit 7 down to bit 0
	typedef struct packed {
		logic pin_guard_enable;
		logic [2:0] unused;
		logic protect_level_hi;
		logic protect_level_lo;
		logic write_latch_bit;
		logic busy_flag;
	} snp_status_s;

	// Frame decoder states
	typedef enum logic [6:0] {
		ST_CMD = 7'h01,
		ST_ADDR = 7'h02,
		ST_RDATA = 7'h04,
		ST_WDATA = 7'h08,
		ST_STWR = 7'h10,
		ST_STRD = 7'h20,
		ST_IGNORE = 7'h40
	} snp_state_e;

endpackage

`default_nettype wire

// ---- bench/snp_spi_host.sv ----
// SPI host model for the serial RAM: mode 0 frames, 6 clk per sck phase.
// Assumes the device samples si on sck rise and drives so after sck fall.
`timescale 1ns/1ps
`default_nettype none

module snp_spi_host (
	// Clock
	input wire logic clk,
	// SPI pins
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so,
	input wire logic so_oe,
	// Received bytes
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic oe_seen
);
	logic so_w;

	// Released output shows the inverted so level, never the last bit
	assign so_w = so_oe ? so : ~so;

	// Idle pins at time zero
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		oe_seen = 1'b0;
	end

	// One frame: tx bytes MSB first, then n_rx bytes read back
	task automatic frame(input logic [7:0] tx[$], input int n_rx);
		logic [7:0] b;
		logic [7:0] r;
		@(posedge clk);
		cs_n <= 1'b0;
		oe_seen <= 1'b0;
		repeat (6) @(posedge clk);
		for (int i = 0; i < tx.size() + n_rx; i++) begin
			// Junk on si during read data, device must ignore it
			b = (i < tx.size()) ? tx[i] : 8'($urandom);
			for (int j = 7; j >= 0; j--) begin
				sck <= 1'b0;
				si <= b[j];
				repeat (6) @(posedge clk);
				r[j] = so_w;
				if (so_oe)
					oe_seen <= 1'b1;
				sck <= 1'b1;
				repeat (6) @(posedge clk);
			end
			if (i >= tx.size()) begin
				rx_byte <= r;
				rx_valid <= 1'b1;
				@(posedge clk);
				rx_valid <= 1'b0;
			end
		end
		sck <= 1'b0;
		repeat (6) @(posedge clk);
		cs_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// ---- bench/test_spi_nvram_protect_access.sv ----
// Self-checking bench for the serial RAM command and protection logic.
// Assumes snp_spi_host as SPI partner; bench drives guard pin and busy.
`timescale 1ns/1ps
`default_nettype none

module test_spi_nvram_protect_access;
	logic clk, rst_n, cs_n, sck, si, so, so_oe, write_guard_n, nv_busy;
	logic store_busy_n, save_req, restore_req, autosave_on_req;
	logic autosave_off_req, rx_valid, oe_seen, quiet;
	logic [7:0] rx_byte;
	logic [7:0] exp_q[$];
	logic [7:0] mem[int];
	logic [1:0] lvl;
	snp_pkg::snp_status_s status;
	int errors, n_checks;
	int n_pulse[4];
	int probes[4] = '{'h0ffff, 'h10000, 'h17fff, 'h18000};
	logic [7:0] sp_ops[4] = '{snp_pkg::OP_SAVE, snp_pkg::OP_RESTORE,
		snp_pkg::OP_AUTO_ON, snp_pkg::OP_AUTO_OFF};

	snp_spi_nvram DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
		.si(si), .so(so), .so_oe(so_oe), .write_guard_n(write_guard_n),
		.nv_busy(nv_busy), .store_busy_n(store_busy_n),
		.save_req(save_req), .restore_req(restore_req),
		.autosave_on_req(autosave_on_req),
		.autosave_off_req(autosave_off_req), .status(status));

	snp_spi_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
		.so_oe(so_oe), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.oe_seen(oe_seen));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Count special command pulses
	always @(posedge clk) begin
		n_pulse[0] += save_req;
		n_pulse[1] += restore_req;
		n_pulse[2] += autosave_on_req;
		n_pulse[3] += autosave_off_req;
	end

	// Compare each received byte with the oldest note
	always @(posedge clk) begin
		if (rx_valid === 1'b1 && !quiet)
			check("so byte", rx_byte, exp_q.pop_front());
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		print_verdict();
	end

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Protected address under the current level
	function automatic bit prot(input int a);
		return lvl == 2'h3 || (lvl == 2'h2 && a >= 'h10000) ||
			(lvl == 2'h1 && a >= 'h18000);
	endfunction

	task automatic cmd(input logic [7:0] op);
		host.frame({op}, 0);
	endtask

	// Latched burst write; the shadow follows only unprotected places
	task automatic wr(input int a, input logic [7:0] d[$]);
		cmd(snp_pkg::OP_SET_LATCH);
		host.frame({snp_pkg::OP_WRITE, 8'hfe | 8'(a >> 16), 8'(a >> 8),
			8'(a), d}, 0);
		foreach (d[i])
			if (!prot((a + i) & 'h1ffff))
				mem[(a + i) & 'h1ffff] = d[i];
	endtask

	task automatic rd(input int a, input int n);
		for (int i = 0; i < n; i++)
			exp_q.push_back(mem[(a + i) & 'h1ffff]);
		host.frame({snp_pkg::OP_READ, 8'hfe | 8'(a >> 16), 8'(a >> 8),
			8'(a)}, n);
	endtask

	task automatic st_wr(input logic [7:0] v);
		cmd(snp_pkg::OP_SET_LATCH);
		host.frame({snp_pkg::OP_STAT_WR, v}, 0);
	endtask

	task automatic st_rd(input logic [7:0] e);
		exp_q.push_back(e);
		host.frame({snp_pkg::OP_STAT_RD}, 1);
	endtask

	// Main sequence
	initial begin
		void'($urandom(51));
		rst_n = 1'b0;
		write_guard_n = 1'b1;
		nv_busy = 1'b0;
		quiet = 1'b0;
		lvl = 2'h0;
		repeat (20) @(posedge clk);
		check("status at reset", status, 8'h00);
		rst_n <= 1'b1;
		cmd(snp_pkg::OP_SET_LATCH);
		st_rd(8'h02);
		cmd(snp_pkg::OP_CLR_LATCH);
		st_rd(8'h00);
		// Mid-run reset drops a set latch
		cmd(snp_pkg::OP_SET_LATCH);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		st_rd(8'h00);
		// Each level in turn, probes on both sides of each boundary
		for (int k = 0; k < 5; k++) begin
			st_wr(8'(k % 4) << 2);
			lvl = 2'(k % 4);
			st_rd(8'(k % 4) << 2);
			foreach (probes[p])
				wr(probes[p], {8'($urandom)});
			foreach (probes[p])
				rd(probes[p], 1);
		end
		// Write and status write with the latch clear are dropped
		host.frame({snp_pkg::OP_WRITE, 8'h00, 8'hff, 8'hff, 8'h5a}, 0);
		rd('h0ffff, 1);
		host.frame({snp_pkg::OP_STAT_WR, 8'h0c}, 0);
		st_rd(8'h00);
		wr('h1fffe, {8'($urandom), 8'($urandom), 8'($urandom)});
		rd('h1fffe, 3);
		// Guard pin
		st_wr(8'h80);
		write_guard_n <= 1'b0;
		st_wr(8'h8c);
		st_rd(8'h80);
		wr('h10, {8'($urandom)});
		rd('h10, 1);
		write_guard_n <= 1'b1;
		st_wr(8'h00);
		write_guard_n <= 1'b0;
		st_wr(8'h04);
		st_rd(8'h04);
		write_guard_n <= 1'b1;
		st_wr(8'h80);
		fork
			st_wr(8'h00);
			begin
				repeat (200) @(posedge clk);
				write_guard_n <= 1'b0;
			end
		join
		st_rd(8'h00);
		write_guard_n <= 1'b1;
		lvl = 2'h0;
		// Array commands refused while the engine runs
		nv_busy <= 1'b1;
		repeat (3) @(posedge clk);
		check("store busy", 8'(store_busy_n), 8'h00);
		st_rd(8'h01);
		quiet = 1'b1;
		host.frame({snp_pkg::OP_READ, 8'h00, 8'h00, 8'h10}, 1);
		quiet = 1'b0;
		check("so enable busy", 8'(oe_seen), 8'h00);
		// Latched write while busy is refused and leaves the latch set
		cmd(snp_pkg::OP_SET_LATCH);
		host.frame({snp_pkg::OP_WRITE, 8'h00, 8'h00, 8'h10, ~mem['h10]}, 0);
		st_rd(8'h03);
		cmd(snp_pkg::OP_CLR_LATCH);
		nv_busy <= 1'b0;
		repeat (3) @(posedge clk);
		check("store idle", 8'(store_busy_n), 8'h01);
		rd('h10, 1);
		// Special commands: none without the latch, one pulse with it
		foreach (sp_ops[k]) begin
			cmd(sp_ops[k]);
			check("pulse sum", 8'(n_pulse.sum()), 8'(k));
			cmd(snp_pkg::OP_SET_LATCH);
			cmd(sp_ops[k]);
			check("pulse", 8'(n_pulse[k]), 8'h01);
			st_rd(8'h00);
		end
		check("notes left", 8'(exp_q.size()), 8'h00);
		print_verdict();
	end
endmodule

`default_nettype wire
